// [logic/fri_sequencer.sv]
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Each reset loads config, protection, option, security
// - Any load error installs protected secured defaults
// - Double-bit fault sets both fault status bits
// - Command complete flag low during init
// - Early init stalls access; reads served afterwards
// - Flag rises at end; commands accepted then
// - Reset aborts a running flash command at the next clock edge
module fri_sequencer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Stored configuration port
    output logic nvm_rd_req_r,
    output logic [1:0] nvm_rd_addr_r,
    input wire logic [31:0] nvm_rd_data,
    input wire logic nvm_rd_valid,
    input wire logic nvm_rd_fault,
    input wire logic nvm_rd_dbl,
    // Loaded configuration
    output logic [31:0] block_config_r,
    output logic [7:0] program_flash_protect_r,
    output logic [7:0] data_flash_protect_r,
    output logic [7:0] flash_option_value_r,
    output logic [7:0] flash_security_value_r,
    // Core and flash array
    output logic cpu_stall_r,
    output logic command_complete_flag_r,
    output logic cmd_active_r,
    output logic [7:0] cmd_opcode_r,
    input wire logic flash_cmd_done,
    // Interrupt
    output logic irq_r
);
    import fri_pkg::*;

    fri_state_t state_r, state_nxt;
    logic [1:0] idx_r;
    logic fetch_go_r;
    logic err_any_r;
    logic [1:0] memory_fault_status_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
    logic dph_r, dph_write_r, dph_word_r;
    logic [7:0] dph_addr_r;

    logic fetch_done, fetch_err, fetch_dbl;
    logic [31:0] fetch_word;

    fri_word_fetch u_fri_word_fetch (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .start(fetch_go_r),
        .idx(idx_r),
        .nvm_rd_req_r(nvm_rd_req_r),
        .nvm_rd_addr_r(nvm_rd_addr_r),
        .nvm_rd_data(nvm_rd_data),
        .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_fault(nvm_rd_fault),
        .nvm_rd_dbl(nvm_rd_dbl),
        .done_r(fetch_done),
        .word_r(fetch_word),
        .err_r(fetch_err),
        .dbl_r(fetch_dbl)
    );

    // Bus decode
    wire ahb_take = hsel && htrans[1] && hready;
    wire complete = dph_r && !cpu_stall_r;
    wire wr_en = complete && dph_write_r && dph_word_r;
    wire wr_status = wr_en && (dph_addr_r == OFS_STATUS);
    wire wr_cmd = wr_en && (dph_addr_r == OFS_CMD);
    wire wr_irq_stat = wr_en && (dph_addr_r == OFS_IRQ_STAT);
    wire wr_irq_mask = wr_en && (dph_addr_r == OFS_IRQ_MASK);

    // Sequencer events
    // A clean last word ends init at once; any error passes through one default cycle
    wire last_word = (idx_r == IDX_OPTSEC);
    wire seq_end = fetch_done && last_word && (state_r == ST_LOAD);
    wire err_total = err_any_r || fetch_err;
    wire enter_ready = (seq_end && !err_total) || (state_r == ST_DEFAULT);
    wire enter_default = seq_end && err_total;
    wire cmd_launch = wr_cmd && command_complete_flag_r && !cmd_active_r;
    wire cmd_finish = cmd_active_r && flash_cmd_done;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_CFG: begin
                if (fetch_done) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (enter_default) begin
                    state_nxt = ST_DEFAULT;
                end else if (seq_end) begin
                    state_nxt = ST_READY;
                end
            end
            ST_DEFAULT: state_nxt = ST_READY;
            ST_READY: state_nxt = ST_READY;
        endcase
    end

    // Sticky bits: hardware set wins over a write-one clear
    wire [IRQ_W-1:0] irq_ev;
    assign irq_ev[IRQ_INIT_DONE] = enter_ready;
    assign irq_ev[IRQ_INIT_FAULT] = enter_default;
    assign irq_ev[IRQ_CMD_DONE] = cmd_finish;
    wire [IRQ_W-1:0] irq_clr = wr_irq_stat ? hwdata[IRQ_W-1:0] : '0;
    wire [IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
    wire [1:0] mfs_clr = wr_status ? hwdata[ST_MFS_LSB+1:ST_MFS_LSB] : 2'h0;
    wire [1:0] mfs_set = (fetch_done && fetch_dbl) ? MFS_DBL : 2'h0;
    wire [1:0] memory_fault_status_nxt = (memory_fault_status_r & ~mfs_clr) | mfs_set;

    // Read data
    wire [31:0] rd_status = {24'h0, command_complete_flag_r, 1'b0, cmd_active_r,
        state_r != ST_READY, 2'h0, memory_fault_status_r};
    wire [31:0] rd_prot = {16'h0, data_flash_protect_r, program_flash_protect_r};
    wire [31:0] rd_optsec = {16'h0, flash_security_value_r, flash_option_value_r};
    wire [31:0] rd_mux =
        (dph_addr_r == OFS_STATUS) ? rd_status :
        (dph_addr_r == OFS_CMD) ? {24'h0, cmd_opcode_r} :
        (dph_addr_r == OFS_PROT) ? rd_prot :
        (dph_addr_r == OFS_OPTSEC) ? rd_optsec :
        (dph_addr_r == OFS_CFG) ? block_config_r :
        (dph_addr_r == OFS_IRQ_STAT) ? {29'h0, irq_stat_r} :
        (dph_addr_r == OFS_IRQ_MASK) ? {29'h0, irq_mask_r} : 32'h0000_0000;

    // Sequencer control
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_r <= ST_CFG;
            idx_r <= IDX_CFG;
            fetch_go_r <= 1'b1;
            err_any_r <= 1'b0;
            cpu_stall_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            fetch_go_r <= fetch_done && !last_word;
            if (fetch_done && !last_word) begin
                idx_r <= idx_r + 2'h1;
            end
            if (fetch_done) begin
                err_any_r <= err_total;
            end
            // Reads may proceed while the remaining words are still loading
            if (state_r == ST_CFG && fetch_done) begin
                cpu_stall_r <= 1'b0;
            end
        end
    end

    // Loaded values, defaults on any error
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            block_config_r <= DEF_BLOCK_CFG;
            program_flash_protect_r <= DEF_PF_PROT;
            data_flash_protect_r <= DEF_DF_PROT;
            flash_option_value_r <= DEF_OPTION;
            flash_security_value_r <= DEF_SECURITY;
        end else if (state_r == ST_DEFAULT) begin
            block_config_r <= DEF_BLOCK_CFG;
            program_flash_protect_r <= DEF_PF_PROT;
            data_flash_protect_r <= DEF_DF_PROT;
            flash_option_value_r <= DEF_OPTION;
            flash_security_value_r <= DEF_SECURITY;
        end else if (fetch_done && !fetch_err) begin
            if (idx_r == IDX_CFG) begin
                block_config_r <= fetch_word;
            end
            if (idx_r == IDX_PROT) begin
                program_flash_protect_r <= fetch_word[PF_LSB+7:PF_LSB];
                data_flash_protect_r <= fetch_word[DF_LSB+7:DF_LSB];
            end
            if (idx_r == IDX_OPTSEC) begin
                flash_option_value_r <= fetch_word[OPT_LSB+7:OPT_LSB];
                flash_security_value_r <= fetch_word[SEC_LSB+7:SEC_LSB];
            end
        end
    end

    // Command flag and command execution
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            command_complete_flag_r <= 1'b0;
            cmd_active_r <= 1'b0;
            cmd_opcode_r <= 8'h00;
            memory_fault_status_r <= 2'h0;
        end else begin
            memory_fault_status_r <= memory_fault_status_nxt;
            if (enter_ready || cmd_finish) begin
                command_complete_flag_r <= 1'b1;
            end else if (cmd_launch) begin
                command_complete_flag_r <= 1'b0;
            end
            if (cmd_launch) begin
                cmd_active_r <= 1'b1;
                cmd_opcode_r <= hwdata[7:0];
            end else if (cmd_finish) begin
                cmd_active_r <= 1'b0;
            end
        end
    end

    // Bus slave: one wait state, longer while the stall holds
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dph_r <= 1'b0;
            dph_write_r <= 1'b0;
            dph_word_r <= 1'b0;
            dph_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else if (ahb_take) begin
            dph_r <= 1'b1;
            dph_write_r <= hwrite;
            dph_word_r <= (hsize == HSIZE_WORD);
            dph_addr_r <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
            hreadyout <= 1'b0;
        end else if (complete) begin
            dph_r <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= dph_write_r ? hrdata : rd_mux;
        end
    end

    // Interrupt registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_stat_r <= '0;
            irq_mask_r <= IRQ_MASK_RST;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (wr_irq_mask) begin
                irq_mask_r <= hwdata[IRQ_W-1:0];
            end
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ccf_low_init_a: assert property (state_r != ST_READY |-> !command_complete_flag_r)
        else $error("command flag high during init");
    ccf_rise_a: assert property (state_r != ST_READY ##1 state_r == ST_READY |-> command_complete_flag_r)
        else $error("command flag not set at init end");
    cmd_refused_a: assert property (wr_cmd && !command_complete_flag_r && !cmd_active_r |=> !cmd_active_r)
        else $error("command taken before init end");
    stall_before_ccf_a: assert property (command_complete_flag_r |-> !cpu_stall_r)
        else $error("stall still held with flag high");
    stall_blocks_a: assert property (dph_r && cpu_stall_r |=> !hreadyout)
        else $error("access completed during stall");
    read_served_a: assert property (dph_r && !cpu_stall_r |=> hreadyout && !dph_r)
        else $error("access not served after stall");
    dbl_fault_a: assert property (fetch_done && fetch_dbl |=> memory_fault_status_r == MFS_DBL)
        else $error("double fault not reported");
    default_prot_a: assert property (enter_default |=> ##1 program_flash_protect_r == DEF_PF_PROT
        && flash_security_value_r == DEF_SECURITY)
        else $error("defaults not applied on error");
    load_prot_a: assert property (fetch_done && !fetch_err && idx_r == IDX_PROT
        |=> program_flash_protect_r == $past(fetch_word[7:0]))
        else $error("protection word not loaded");
    reset_abort_a: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n |=> !cmd_active_r)
        else $error("command survived reset");
    fault_irq_a: assert property (enter_default |=> irq_stat_r[IRQ_INIT_FAULT])
        else $error("init fault event lost");
    cmd_launch_a: assert property (cmd_launch |=> cmd_active_r && !command_complete_flag_r)
        else $error("command launch not applied");
    fetch_order_a: assert property (fetch_go_r |-> !nvm_rd_req_r)
        else $error("fetch started over a pending request");
    ready_stays_a: assert property (state_r == ST_READY |=> state_r == ST_READY)
        else $error("sequencer left the ready state");

    init_clean_c: cover property (seq_end && !err_total);
    init_fault_c: cover property (enter_default);
    cmd_done_c: cover property (cmd_launch ##[1:50] cmd_finish);
    stalled_read_c: cover property (dph_r && cpu_stall_r ##[1:200] complete && !dph_write_r);
    store_silent_c: cover property (fetch_done && fetch_err && !fetch_dbl && idx_r == IDX_CFG);

endmodule : fri_sequencer

`default_nettype wire

// [pkg/fri_pkg.sv]
`default_nettype none

package fri_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int FETCH_TMO_NS = 10000;
    localparam int FETCH_TMO_CYC = FETCH_TMO_NS / CLK_PERIOD_NS;
    localparam int FETCH_TMO_W = $clog2(FETCH_TMO_CYC + 1);

    // Register byte offsets
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_PROT = 8'h08;
    localparam logic [7:0] OFS_OPTSEC = 8'h0c;
    localparam logic [7:0] OFS_CFG = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // Status register fields
    localparam int ST_MFS_LSB = 0;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_CMDACT_BIT = 5;
    localparam int ST_CCF_BIT = 7;
    localparam logic [1:0] MFS_DBL = 2'h3;

    // Interrupt status and mask fields
    localparam int IRQ_W = 3;
    localparam int IRQ_INIT_DONE = 0;
    localparam int IRQ_INIT_FAULT = 1;
    localparam int IRQ_CMD_DONE = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Stored word indices and packed field positions
    localparam logic [1:0] IDX_CFG = 2'h0;
    localparam logic [1:0] IDX_PROT = 2'h1;
    localparam logic [1:0] IDX_OPTSEC = 2'h2;
    localparam int PF_LSB = 0;
    localparam int DF_LSB = 8;
    localparam int OPT_LSB = 0;
    localparam int SEC_LSB = 8;

    // Fully protected, secured defaults
    localparam logic [31:0] DEF_BLOCK_CFG = 32'h0000_0000;
    localparam logic [7:0] DEF_PF_PROT = 8'hff;
    localparam logic [7:0] DEF_DF_PROT = 8'hff;
    localparam logic [7:0] DEF_OPTION = 8'hff;
    localparam logic [7:0] DEF_SECURITY = 8'hff;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        ST_CFG = 2'b00,
        ST_LOAD = 2'b01,
        ST_DEFAULT = 2'b10,
        ST_READY = 2'b11
    } fri_state_t;

endpackage : fri_pkg

`default_nettype wire

// [logic/fri_word_fetch.sv]
`timescale 1ns/1ns
`default_nettype none

module fri_word_fetch (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Request from sequencer
    input wire logic start,
    input wire logic [1:0] idx,
    // Stored configuration port
    output logic nvm_rd_req_r,
    output logic [1:0] nvm_rd_addr_r,
    input wire logic [31:0] nvm_rd_data,
    input wire logic nvm_rd_valid,
    input wire logic nvm_rd_fault,
    input wire logic nvm_rd_dbl,
    // Result
    output logic done_r,
    output logic [31:0] word_r,
    output logic err_r,
    output logic dbl_r
);
    import fri_pkg::*;

    logic [FETCH_TMO_W-1:0] cnt_r;
    wire timeout = nvm_rd_req_r && (cnt_r == FETCH_TMO_W'(FETCH_TMO_CYC - 1));
    wire got = nvm_rd_req_r && nvm_rd_valid;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            nvm_rd_req_r <= 1'b0;
            nvm_rd_addr_r <= 2'h0;
            cnt_r <= '0;
            done_r <= 1'b0;
            word_r <= 32'h0000_0000;
            err_r <= 1'b0;
            dbl_r <= 1'b0;
        end else begin
            done_r <= got || timeout;
            if (start) begin
                nvm_rd_req_r <= 1'b1;
                nvm_rd_addr_r <= idx;
                cnt_r <= '0;
            end else if (got) begin
                nvm_rd_req_r <= 1'b0;
                word_r <= nvm_rd_data;
                err_r <= nvm_rd_fault || nvm_rd_dbl;
                dbl_r <= nvm_rd_dbl;
            end else if (timeout) begin
                // A silent store counts as a load error
                nvm_rd_req_r <= 1'b0;
                err_r <= 1'b1;
                dbl_r <= 1'b0;
            end else if (nvm_rd_req_r) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule : fri_word_fetch

`default_nettype wire

// [tb/fri_store_model.sv]
`timescale 1ns/1ns
`default_nettype none

module fri_store_model (
    // Clock
    input wire logic sys_clk,
    // Stored configuration port
    input wire logic nvm_rd_req_r,
    input wire logic [1:0] nvm_rd_addr_r,
    output logic [31:0] nvm_rd_data,
    output logic nvm_rd_valid,
    output logic nvm_rd_fault,
    output logic nvm_rd_dbl,
    // Flash array
    input wire logic cmd_active_r,
    output logic flash_cmd_done,
    // Scenario controls
    input wire logic [3:0] lat,
    input wire logic [1:0] bad_idx,
    input wire logic bad_dbl,
    input wire logic hold_cmd
);
    logic [3:0] wait_cnt;
    logic [3:0] cmd_cnt;

    function automatic logic [31:0] stored(input logic [1:0] idx);
        case (idx)
            2'h0: stored = 32'h1234_5678;
            2'h1: stored = 32'h0000_a55a;
            2'h2: stored = 32'h0000_3cc3;
            default: stored = 32'h0000_0000;
        endcase
    endfunction : stored

    initial begin
        nvm_rd_data = 32'h0000_0000;
        {nvm_rd_valid, nvm_rd_fault, nvm_rd_dbl, flash_cmd_done} = 4'h0;
        wait_cnt = 4'h0;
        cmd_cnt = 4'h0;
    end

    always @(posedge sys_clk) begin
        {nvm_rd_valid, nvm_rd_fault, nvm_rd_dbl, flash_cmd_done} <= 4'h0;
        // Data outside a valid pulse keeps toggling so stale values never look good
        nvm_rd_data <= ~nvm_rd_data;
        // All ones in lat models a store that never answers
        if (!nvm_rd_req_r || nvm_rd_valid) begin
            wait_cnt <= 4'h0;
        end else if (wait_cnt == lat && lat != 4'hf) begin
            wait_cnt <= 4'h0;
            nvm_rd_valid <= 1'b1;
            nvm_rd_data <= stored(nvm_rd_addr_r);
            nvm_rd_fault <= (nvm_rd_addr_r == bad_idx) && !bad_dbl;
            nvm_rd_dbl <= (nvm_rd_addr_r == bad_idx) && bad_dbl;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
        if (!cmd_active_r || flash_cmd_done) begin
            cmd_cnt <= 4'h0;
        end else if (cmd_cnt == 4'h5 && !hold_cmd) begin
            flash_cmd_done <= 1'b1;
        end else begin
            cmd_cnt <= cmd_cnt + 4'h1;
        end
    end
endmodule : fri_store_model

`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import fri_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, nvm_rd_data, block_config_r, rd;
    logic [1:0] htrans = 2'h0, nvm_rd_addr_r, bad_idx = 2'h3;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, nvm_rd_req_r, nvm_rd_valid, nvm_rd_fault, nvm_rd_dbl, cpu_stall_r;
    logic command_complete_flag_r, cmd_active_r, flash_cmd_done, irq_r, bad_dbl = 1'b0, hold_cmd = 1'b0;
    logic [7:0] program_flash_protect_r, data_flash_protect_r, flash_option_value_r, flash_security_value_r;
    logic [7:0] cmd_opcode_r;
    logic [3:0] lat = 4'h3;
    int errors = 0, cmp_count = 0, cyc = 0;

    fri_sequencer u_fri_sequencer (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nvm_rd_req_r(nvm_rd_req_r),
        .nvm_rd_addr_r(nvm_rd_addr_r), .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_fault(nvm_rd_fault), .nvm_rd_dbl(nvm_rd_dbl), .block_config_r(block_config_r),
        .program_flash_protect_r(program_flash_protect_r), .data_flash_protect_r(data_flash_protect_r),
        .flash_option_value_r(flash_option_value_r), .flash_security_value_r(flash_security_value_r),
        .cpu_stall_r(cpu_stall_r), .command_complete_flag_r(command_complete_flag_r),
        .cmd_active_r(cmd_active_r), .cmd_opcode_r(cmd_opcode_r), .flash_cmd_done(flash_cmd_done),
        .irq_r(irq_r));
    fri_store_model u_fri_store_model (.sys_clk(sys_clk), .nvm_rd_req_r(nvm_rd_req_r),
        .nvm_rd_addr_r(nvm_rd_addr_r), .nvm_rd_data(nvm_rd_data), .nvm_rd_valid(nvm_rd_valid),
        .nvm_rd_fault(nvm_rd_fault), .nvm_rd_dbl(nvm_rd_dbl), .cmd_active_r(cmd_active_r),
        .flash_cmd_done(flash_cmd_done), .lat(lat), .bad_idx(bad_idx), .bad_dbl(bad_dbl),
        .hold_cmd(hold_cmd));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One single word transfer; entered right after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wdata;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb

    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
    endtask : do_reset

    task automatic wait_flag;
        while (command_complete_flag_r !== 1'b1) @(posedge sys_clk);
    endtask : wait_flag

    task automatic chk_loaded(input logic [31:0] cfg, input logic [15:0] prot, input logic [15:0] os);
        ahb(1'b0, {24'h0, OFS_PROT}, 32'h0);
        chk("prot", {16'h0, prot}, rd);
        ahb(1'b0, {24'h0, OFS_OPTSEC}, 32'h0);
        chk("optsec", {16'h0, os}, rd);
        ahb(1'b0, {24'h0, OFS_CFG}, 32'h0);
        chk("cfg", cfg, rd);
        chk("cfg port", cfg, block_config_r);
        chk("prot port", {16'h0, prot}, {16'h0, data_flash_protect_r, program_flash_protect_r});
        chk("optsec port", {16'h0, os}, {16'h0, flash_security_value_r, flash_option_value_r});
    endtask : chk_loaded

    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk("flag at release", 32'h0, {31'h0, command_complete_flag_r});
        chk("stall at release", 32'h1, {31'h0, cpu_stall_r});
        ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk("status in init", 32'h10, rd);
        chk("stall after read", 32'h0, {31'h0, cpu_stall_r});
        chk("flag after read", 32'h0, {31'h0, command_complete_flag_r});
        wait_flag();
        chk("stall at flag", 32'h0, {31'h0, cpu_stall_r});
        chk_loaded(32'h1234_5678, 16'ha55a, 16'h3cc3);
        ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk("status clean", 32'h80, rd);
        ahb(1'b0, {24'h0, OFS_IRQ_STAT}, 32'h0);
        chk("irq stat init", 32'h1, rd);
        chk("irq masked", 32'h0, {31'h0, irq_r});
        ahb(1'b1, {24'h0, OFS_IRQ_MASK}, 32'h7);
        ahb(1'b0, {24'h0, OFS_IRQ_MASK}, 32'h0);
        chk("irq mask", 32'h7, rd);
        chk("irq raised", 32'h1, {31'h0, irq_r});
        ahb(1'b1, {24'h0, OFS_IRQ_STAT}, 32'h1);
        ahb(1'b0, {24'h0, OFS_IRQ_STAT}, 32'h0);
        chk("irq stat cleared", 32'h0, rd);
        chk("irq low", 32'h0, {31'h0, irq_r});
        ahb(1'b0, 32'h0000_0100, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, {24'h0, OFS_CMD}, 32'h5a);
        chk("cmd active", 32'h1, {31'h0, cmd_active_r});
        chk("flag busy", 32'h0, {31'h0, command_complete_flag_r});
        wait_flag();
        ahb(1'b0, {24'h0, OFS_CMD}, 32'h0);
        chk("opcode", 32'h5a, rd);
        ahb(1'b0, {24'h0, OFS_IRQ_STAT}, 32'h0);
        chk("cmd done irq", 32'h4, rd);
        chk("irq cmd", 32'h1, {31'h0, irq_r});
        // Reset in mid-command aborts it
        hold_cmd <= 1'b1;
        ahb(1'b1, {24'h0, OFS_CMD}, 32'h33);
        chk("held cmd", 32'h1, {31'h0, cmd_active_r});
        rst_n <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        chk("aborted", 32'h0, {31'h0, cmd_active_r});
        chk("flag in reset", 32'h0, {31'h0, command_complete_flag_r});
        // Single fault with a prompt store, command tried during init
        hold_cmd <= 1'b0;
        lat <= 4'h0;
        bad_idx <= 2'h1;
        do_reset(2);
        ahb(1'b1, {24'h0, OFS_CMD}, 32'h21);
        wait_flag();
        chk("early cmd refused", 32'h0, {31'h0, cmd_active_r});
        chk_loaded(DEF_BLOCK_CFG, {DEF_DF_PROT, DEF_PF_PROT}, {DEF_SECURITY, DEF_OPTION});
        ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk("single fault status", 32'h0, {30'h0, rd[1:0]});
        ahb(1'b0, {24'h0, OFS_IRQ_STAT}, 32'h0);
        chk("fault irq", 32'h2, rd & 32'h2);
        // Double fault on the last word
        lat <= 4'h3;
        bad_idx <= 2'h2;
        bad_dbl <= 1'b1;
        do_reset(3);
        wait_flag();
        ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk("double fault status", {30'h0, MFS_DBL}, {30'h0, rd[1:0]});
        chk_loaded(DEF_BLOCK_CFG, {DEF_DF_PROT, DEF_PF_PROT}, {DEF_SECURITY, DEF_OPTION});
        // Silent store: every word times out and counts as an error
        lat <= 4'hf;
        do_reset(2);
        wait_flag();
        chk_loaded(DEF_BLOCK_CFG, {DEF_DF_PROT, DEF_PF_PROT}, {DEF_SECURITY, DEF_OPTION});
        ahb(1'b0, {24'h0, OFS_STATUS}, 32'h0);
        chk("timeout status", 32'h80, rd);
        test_done();
    end
endmodule : tb_top

`default_nettype wire
